// file: logic/pulse_unit_map.vh
// register offsets, field positions and reset values of the pulse output unit
`ifndef PULSE_UNIT_MAP_VH
`define PULSE_UNIT_MAP_VH
`define OFS_ROUTE 12'h000
`define OFS_ENABLE 12'h004
`define OFS_CONFIG 12'h008
`define OFS_COUNT 12'h00c
`define OFS_STAGE_PERIOD 12'h010
`define OFS_STAGE_HIGH 12'h014
`define OFS_COMMIT 12'h018
`define OFS_STOP 12'h01c
`define OFS_STANDBY 12'h020
`define OFS_STATUS 12'h024
`define OFS_DELAY 12'h028
`define CFG_TAKEOVER_BIT 0
`define CFG_COUNTED_BIT 1
`define CFG_STOP_NOW_BIT 2
`define CFG_START_LEVEL_BIT 3
`define CFG_POLARITY_BIT 4
`define RST_CONFIG 5'h00
`define RST_COUNT 32'h00000001
`define TICK_NS 25
`define CLK_NS 10
`endif

// file: logic/pulse_output_unit.v
// single-channel latched pulse-width output unit with apb register access
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
`include "pulse_unit_map.vh"
module pulse_output_unit #(
    parameter CNT_W = 32
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire digital_out_value,
    output reg pin_out
);
    // a tick never runs short: 2.5 clocks round up to 3
    localparam integer TICK_DIV_I = `TICK_NS / `CLK_NS + ((`TICK_NS % `CLK_NS) != 0 ? 1 : 0);
    localparam [3:0] TICK_DIV = TICK_DIV_I[3:0];
    localparam [1:0] ST_IDLE = 2'd0;
    localparam [1:0] ST_DELAY = 2'd1;
    localparam [1:0] ST_RUN = 2'd2;

    reg route_reg;
    reg enable_reg;
    reg [4:0] config_reg;
    reg [CNT_W-1:0] count_reg;
    reg [CNT_W-1:0] stage_period_reg;
    reg [CNT_W-1:0] stage_high_reg;
    reg committed_reg;
    reg standby_reg;
    reg [CNT_W-1:0] delay_reg;
    reg [CNT_W-1:0] act_period_reg;
    reg [CNT_W-1:0] act_high_reg;
    reg pending_reg;
    reg [1:0] state_reg;
    reg [3:0] div_reg;
    reg [CNT_W-1:0] tick_reg;
    reg [CNT_W-1:0] periods_reg;
    reg stop_req_reg;

    wire wr = psel && penable && pwrite;
    wire rd_setup = psel && !penable && !pwrite;
    wire tick = (div_reg == TICK_DIV - 4'd1);
    wire period_end = tick && (tick_reg >= act_period_reg - {{(CNT_W-1){1'b0}}, 1'b1});
    wire wr_commit = wr && paddr == `OFS_COMMIT && pwdata[0];
    wire wr_stop = wr && paddr == `OFS_STOP && pwdata[0];
    wire wr_enable = wr && paddr == `OFS_ENABLE;
    wire counted = config_reg[`CFG_COUNTED_BIT];
    wire last_period = counted && (periods_reg + {{(CNT_W-1){1'b0}}, 1'b1} >= count_reg);
    wire first_half = tick_reg < act_high_reg;
    wire active_level = config_reg[`CFG_START_LEVEL_BIT] ^ ~config_reg[`CFG_POLARITY_BIT] ? first_half : ~first_half;

    function mapped;
        input [11:0] a;
        begin
            mapped = (a[1:0] == 2'b00) && (a <= `OFS_DELAY);
        end
    endfunction

    // apb slave, zero wait states
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            route_reg <= 1'b0;
            enable_reg <= 1'b0;
            config_reg <= `RST_CONFIG;
            count_reg <= `RST_COUNT;
            stage_period_reg <= {CNT_W{1'b0}};
            stage_high_reg <= {CNT_W{1'b0}};
            standby_reg <= 1'b0;
            delay_reg <= {CNT_W{1'b0}};
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped(paddr);
            if (wr) begin
                case (paddr)
                    `OFS_ROUTE: route_reg <= pwdata[0];
                    `OFS_ENABLE: enable_reg <= pwdata[0];
                    `OFS_CONFIG: config_reg <= pwdata[4:0];
                    `OFS_COUNT: count_reg <= pwdata[CNT_W-1:0];
                    `OFS_STAGE_PERIOD: stage_period_reg <= pwdata[CNT_W-1:0];
                    `OFS_STAGE_HIGH: stage_high_reg <= pwdata[CNT_W-1:0];
                    `OFS_STANDBY: standby_reg <= pwdata[0];
                    `OFS_DELAY: delay_reg <= pwdata[CNT_W-1:0];
                    default: ;
                endcase
            end
            // unless that cycle writes enable 1, a finished run or stop clears enable so status and enable agree
            if (state_reg != ST_IDLE && !(wr_enable && pwdata[0]) &&
                    (wr_stop || (stop_req_reg && period_end) || (period_end && last_period))) begin
                enable_reg <= 1'b0;
            end
            if (rd_setup) begin
                case (paddr)
                    `OFS_ROUTE: prdata <= {31'h0, route_reg};
                    `OFS_ENABLE: prdata <= {31'h0, enable_reg};
                    `OFS_CONFIG: prdata <= {27'h0, config_reg};
                    `OFS_COUNT: prdata <= count_reg;
                    `OFS_STAGE_PERIOD: prdata <= stage_period_reg;
                    `OFS_STAGE_HIGH: prdata <= stage_high_reg;
                    `OFS_STANDBY: prdata <= {31'h0, standby_reg};
                    `OFS_STATUS: prdata <= {31'h0, state_reg != ST_IDLE};
                    `OFS_DELAY: prdata <= delay_reg;
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // generator
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_period_reg <= {CNT_W{1'b0}};
            act_high_reg <= {CNT_W{1'b0}};
            committed_reg <= 1'b0;
            pending_reg <= 1'b0;
            state_reg <= ST_IDLE;
            div_reg <= 4'h0;
            tick_reg <= {CNT_W{1'b0}};
            periods_reg <= {CNT_W{1'b0}};
            stop_req_reg <= 1'b0;
            pin_out <= 1'b0;
        end else begin
            div_reg <= (state_reg == ST_IDLE || tick) ? 4'h0 : div_reg + 4'h1;
            if (wr_commit) begin
                committed_reg <= 1'b1;
                if (config_reg[`CFG_TAKEOVER_BIT] || state_reg != ST_RUN) begin
                    act_period_reg <= stage_period_reg;
                    act_high_reg <= stage_high_reg;
                    pending_reg <= 1'b0;
                end else begin
                    pending_reg <= 1'b1;
                end
            end else if (pending_reg && period_end) begin
                act_period_reg <= stage_period_reg;
                act_high_reg <= stage_high_reg;
                pending_reg <= 1'b0;
            end
            case (state_reg)
                ST_IDLE: begin
                    stop_req_reg <= 1'b0;
                    tick_reg <= {CNT_W{1'b0}};
                    periods_reg <= {CNT_W{1'b0}};
                    if (wr_enable && pwdata[0] && !wr_stop) begin
                        state_reg <= ST_DELAY;
                    end
                end
                ST_DELAY: begin
                    if (wr_stop || (wr_enable && !pwdata[0])) begin
                        state_reg <= ST_IDLE;
                    end else if (tick_reg >= delay_reg) begin
                        tick_reg <= {CNT_W{1'b0}};
                        if (committed_reg) begin
                            state_reg <= ST_RUN;
                        end
                    end else if (tick) begin
                        tick_reg <= tick_reg + {{(CNT_W-1){1'b0}}, 1'b1};
                    end
                end
                ST_RUN: begin
                    if (wr_enable && !pwdata[0]) begin
                        if (config_reg[`CFG_STOP_NOW_BIT]) begin
                            state_reg <= ST_IDLE;
                        end else begin
                            stop_req_reg <= 1'b1;
                        end
                    end
                    if (wr_stop) begin
                        state_reg <= ST_IDLE;
                    end else if (period_end) begin
                        tick_reg <= {CNT_W{1'b0}};
                        periods_reg <= periods_reg + {{(CNT_W-1){1'b0}}, 1'b1};
                        if (stop_req_reg || last_period) begin
                            state_reg <= ST_IDLE;
                        end
                    end else if (tick) begin
                        tick_reg <= tick_reg + {{(CNT_W-1){1'b0}}, 1'b1};
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
            if (!route_reg) begin
                pin_out <= digital_out_value;
            end else if (state_reg == ST_RUN) begin
                pin_out <= active_level;
            end else begin
                pin_out <= standby_reg;
            end
        end
    end
endmodule

// file: tb/pulse_output_unit_sva.sv
// port-level assertion checker for the pulse output unit
`timescale 1ns/1ps
`include "pulse_unit_map.vh"
module pulse_output_unit_sva (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire digital_out_value,
    input wire pin_out
);
    reg route_reg;
    reg standby_reg;
    wire wr = psel && penable && pwrite && pready && !pslverr;
    wire setup = psel && !penable;
    // shadow copies so pin checks need no view inside the design
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            route_reg <= 1'b0;
            standby_reg <= 1'b0;
        end else begin
            route_reg <= (wr && paddr == `OFS_ROUTE) ? pwdata[0] : route_reg;
            standby_reg <= (wr && paddr == `OFS_STANDBY) ? pwdata[0] : standby_reg;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_after_setup_a: assert property (setup |=> pready) else $error("ready missing");
    ready_in_access_a: assert property (pready |-> psel && penable) else $error("stray ready");
    err_with_ready_a: assert property (pslverr |-> pready) else $error("stray error");
    unmapped_err_a: assert property (setup && (paddr > `OFS_DELAY || paddr[1:0] != 2'b00) |=> pslverr)
        else $error("unmapped not refused");
    bad_read_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("bad read data");
    plain_route_a: assert property (!route_reg |=> pin_out == $past(digital_out_value))
        else $error("pin not plain output");
    stop_standby_a: assert property (wr && paddr == `OFS_STOP && pwdata[0] && route_reg |-> ##[1:4] pin_out == standby_reg)
        else $error("stop not at standby");
    status_narrow_a: assert property (pready && !pwrite && paddr == `OFS_STATUS |-> prdata[31:1] == 31'h0)
        else $error("status wide");
    cover property (wr && paddr == `OFS_STOP);
    cover property (route_reg && $rose(pin_out));
    cover property (pready && pslverr);
endmodule
bind pulse_output_unit pulse_output_unit_sva u_pulse_output_unit_sva (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .digital_out_value(digital_out_value), .pin_out(pin_out));

// file: tb/pin_load.sv
// load on the pulse pin: counts rising edges and times the last high stretch
`timescale 1ns/1ps
module pin_load (
    input wire logic clk,
    input wire logic pin,
    output int rises,
    output int high_len
);
    int run = 0;
    logic last = 1'b0;
    initial rises = 0;
    initial high_len = 0;
    always @(posedge clk) begin
        last <= pin;
        run <= pin ? run + 1 : 0;
        if (!pin && last) high_len <= run;
        if (pin && !last) rises <= rises + 1;
    end
endmodule

// file: tb/pulse_output_unit_test.sv
// self-checking testbench of the latched pulse output unit
`timescale 1ns/1ps
`include "pulse_unit_map.vh"
module pulse_output_unit_test;
    logic pclk, presetn, psel, penable, pwrite, digital_out_value, pready, pslverr, pin_out, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] ra[$] = '{`OFS_ROUTE, `OFS_CONFIG, `OFS_COUNT, `OFS_STANDBY, `OFS_STATUS};
    logic [31:0] re[$] = '{32'h0, `RST_CONFIG, `RST_COUNT, 32'h0, 32'h0};
    int err_count, samples_checked, rises, high_len, seed, p, h, n, k, m, t;
    pulse_output_unit u_pulse_output_unit (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .digital_out_value(digital_out_value), .pin_out(pin_out));
    pin_load u_pin_load (.clk(pclk), .pin(pin_out), .rises(rises), .high_len(high_len));
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        if (i >= 16) begin
            err_count++;
            end_of_test();
        end
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    initial begin
        pclk = 0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        {psel, penable, pwrite, digital_out_value, presetn, paddr, pwdata} = 0;
        seed = 25743;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ra[i]) begin
            apb(0, ra[i], 0);
            chk(rd, re[i]);
        end
        apb(0, 12'h02c, 0);
        chk({er, rd}, {1'b1, 32'h0});
        repeat (4) begin
            @(posedge pclk) digital_out_value <= $random(seed);
            @(negedge pclk) @(negedge pclk) chk(pin_out, digital_out_value);
        end
        // every start level and polarity pair, counted runs; duty kept strictly inside the period
        for (k = 0; k < 4; k++) begin
            p = 4 + ($random(seed) & 3);
            h = 1 + ({$random(seed)} % (p - 1));
            n = 2 + k;
            apb(1, `OFS_CONFIG, {k[1:0], 3'b010});
            apb(1, `OFS_COUNT, n);
            apb(1, `OFS_STAGE_PERIOD, p);
            apb(1, `OFS_STAGE_HIGH, h);
            apb(1, `OFS_COMMIT, 1);
            apb(1, `OFS_ROUTE, 1);
            apb(1, `OFS_DELAY, 20);
            m = rises;
            apb(1, `OFS_ENABLE, 1);
            apb(0, `OFS_STATUS, 0);
            chk({pin_out, rd}, {1'b0, 32'h1});
            t = 0;
            do begin
                apb(0, `OFS_STATUS, 0);
                t++;
            end while (rd[0] !== 1'b0 && t < 200);
            chk(t < 200, 1);
            if (t >= 200) end_of_test();
            chk(rises - m, n);
            chk(high_len, ((k == 0 || k == 3) ? h : p - h) * 3);
            apb(0, `OFS_ENABLE, 0);
            chk({pin_out, rd}, 33'h0);
        end
        apb(1, `OFS_STANDBY, 1);
        apb(1, `OFS_CONFIG, 5'h08);
        apb(1, `OFS_DELAY, 0);
        m = rises;
        apb(1, `OFS_ENABLE, 1);
        repeat (200) @(posedge pclk);
        chk(rises - m > 1, 1);
        apb(1, `OFS_STOP, 1);
        apb(0, `OFS_STATUS, 0);
        chk({pin_out, rd}, {1'b1, 32'h0});
        // stop-now mode: a disable write halts the run at once
        apb(1, `OFS_CONFIG, 5'h04);
        apb(1, `OFS_ENABLE, 1);
        repeat (100) @(posedge pclk);
        apb(1, `OFS_ENABLE, 0);
        apb(0, `OFS_STATUS, 0);
        chk({pin_out, rd}, {1'b1, 32'h0});
        end_of_test();
    end
endmodule
